// ===== bench/test_tws_unit.sv
// self-checking bench of the timer/watchdog register set
`timescale 1ns/10ps
`include "tws_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module test_tws_unit;
    import tws_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    tws_addr_t addr_in = '0;
    logic [15:0] wdata_in = '0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic freeze_in = 1'b0;
    logic [15:0] rdata_out;
    logic irq, uf, err;
    int fails = 0;
    int n_checks = 0;
    int p0, p1, k;
    logic [15:0] r, v;
    tws_addr_t ra[6] = '{`TWS_OFF_CFG, `TWS_OFF_PRE, `TWS_OFF_RLD, `TWS_OFF_CSR, `TWS_OFF_WSM,
        24'hFFFF2E};
    logic [15:0] re[6] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
    tws_unit #(.SLOW_DIV(2)) i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .freeze_in(freeze_in),
        .rdata_out(rdata_out), .timer_irq_out(irq), .timer_underflow_out(uf),
        .watchdog_error_out(err));
    // 20 MHz clock
    always #25 mclk_in = ~mclk_in;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        rst_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic wr(input tws_addr_t a, input logic [15:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input tws_addr_t a, output logic [15:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // bounded wait on underflow (0) or error (1); a selector keeps free tools happy
    task automatic await(input int which, input logic lvl, inout int n);
        int c;
        c = 0;
        while (((which == 0) ? uf : err) !== lvl)
        begin
            @(posedge mclk_in);
            #1 n++;
            c++;
            if (c > 4000)
            begin
                fails++;
                stop_test();
            end
        end
    endtask
    // restart with new settings; first intervals dropped as they may be partial
    task automatic tmr(input logic [15:0] rl, input logic [15:0] pc, output int n);
        wr(`TWS_OFF_RLD, rl);
        wr(`TWS_OFF_PRE, pc);
        wr(`TWS_OFF_CSR, 16'h0001);
        repeat (3)
        begin
            n = 0;
            await(0, 1'b0, n);
            await(0, 1'b1, n);
        end
    endtask
    initial
    begin
        void'($urandom(18680));
        do_reset();
        for (int i = 0; i < 6; i++)
        begin
            rd(ra[i], r);
            `CHK(r, re[i])
        end
        // random read-back with boundary reload values first
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 16'h0001 : (i == 1) ? 16'hFFFF : 16'($urandom_range(65535, 1));
            wr(`TWS_OFF_RLD, v);
            rd(`TWS_OFF_RLD, r);
            `CHK(r, v)
            v = 16'($urandom_range(5, 0));
            wr(`TWS_OFF_PRE, v);
            rd(`TWS_OFF_PRE, r);
            `CHK(r, v)
            v = {10'h000, 2'($urandom), 4'h0};
            wr(`TWS_OFF_CFG, v);
            rd(`TWS_OFF_CFG, r);
            `CHK(r, v)
        end
        // periods relative to reload 1, divide by 1
        tmr(16'h0001, 16'h0000, p0);
        tmr(16'h0003, 16'h0000, p1);
        `CHK(p1, 2 * p0)
        tmr(16'h0001, 16'h0001, p1);
        `CHK(p1, 2 * p0)
        tmr(16'h0001, 16'h0005, p1);
        `CHK(p1, 32 * p0)
        tmr(16'h0008, 16'h0000, p1);
        `CHK(2 * p1, 9 * p0)
        wr(`TWS_OFF_CSR, 16'h0004);
        tick(2);
        `CHK(irq, 1'b1)
        rd(`TWS_OFF_CSR, r);
        `CHK(r[2:1], 2'b11)
        // freeze first, so no underflow can set the flag again behind the clear
        @(posedge mclk_in);
        freeze_in <= 1'b1;
        wr(`TWS_OFF_CSR, 16'h0014);
        tick(2);
        wr(`TWS_OFF_CSR, 16'h0016);
        tick(40);
        `CHK(irq, 1'b0)
        rd(`TWS_OFF_CSR, r);
        `CHK(r[4:1], 4'b1010)
        @(posedge mclk_in);
        freeze_in <= 1'b0;
        wr(`TWS_OFF_CSR, 16'h0001);
        tick(20);
        rd(`TWS_OFF_CSR, r);
        `CHK(r[0], 1'b0)
        // locked timer settings keep the old period, even after a zero write
        wr(`TWS_OFF_CFG, 16'h0006);
        tmr(16'h0003, 16'h0005, p1);
        `CHK(2 * p1, 9 * p0)
        wr(`TWS_OFF_CFG, 16'h0000);
        tmr(16'h0003, 16'h0005, p1);
        `CHK(2 * p1, 9 * p0)
        do_reset();
        wr(`TWS_OFF_CFG, 16'h0001);
        wr(`TWS_OFF_CFG, 16'h0002);
        tmr(16'h0003, 16'h0000, p1);
        `CHK(p1, 2 * p0)
        wr(`TWS_OFF_MODE, 16'h0001);
        wr(`TWS_OFF_PRE, 16'h0005);
        wr(`TWS_OFF_MODE, 16'h0000);
        rd(`TWS_OFF_PRE, r);
        `CHK(r, 16'h0000)
        // watchdog idle, then clock select, then late service
        do_reset();
        wr(`TWS_OFF_CFG, 16'h0010);
        tick(600);
        `CHK(err, 1'b0)
        wr(`TWS_OFF_CFG, 16'h0000);
        wr(`TWS_OFF_WDC, 16'h0003);
        tick(300);
        `CHK(err, 1'b0)
        rd(`TWS_OFF_WDC, r);
        `CHK(r, 16'h0003)
        wr(`TWS_OFF_CFG, 16'h0010);
        await(1, 1'b1, k);
        `CHK(err, 1'b1)
        do_reset();
        wr(`TWS_OFF_WSM, 16'h00A3);
        tick(20);
        `CHK(err, 1'b0)
        // too often: start write, then two services before any decrement
        do_reset();
        tick(20);
        wr(`TWS_OFF_WDC, 16'h0032);
        wr(`TWS_OFF_WDC, 16'h0032);
        wr(`TWS_OFF_WDC, 16'h0032);
        await(1, 1'b1, k);
        `CHK(err, 1'b1)
        do_reset();
        wr(`TWS_OFF_CFG, 16'h0030);
        wr(`TWS_OFF_WDC, 16'h0028);
        for (int i = 0; i < 10; i++)
        begin
            tick(20);
            if (i == 5)
                wr(`TWS_OFF_MODE, 16'h0001);
            if (i == 7)
                wr(`TWS_OFF_MODE, 16'h0002);
            wr(`TWS_OFF_WSM, 16'h005C);
        end
        `CHK(err, 1'b0)
        wr(`TWS_OFF_WSM, 16'h00A3);
        await(1, 1'b1, k);
        `CHK(err, 1'b1)
        stop_test();
    end
endmodule

// ===== bench/tws_unit_properties.sv
// concurrent checks on the port relations of the timer/watchdog unit
`timescale 1ns/10ps
`include "tws_map.svh"
module tws_unit_properties #(
    parameter int SLOW_DIV = 2
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire tws_pkg::tws_addr_t addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic freeze_in,
    input wire logic [15:0] rdata_out,
    input wire logic timer_irq_out,
    input wire logic timer_underflow_out,
    input wire logic watchdog_error_out
);
    import tws_pkg::*;
    logic started_r;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // any write to count or match counts, refused or not, so this is a superset
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            started_r <= 1'b0;
        else if (wr_in && (addr_in == `TWS_OFF_WDC || addr_in == `TWS_OFF_WSM))
            started_r <= 1'b1;
    end
    // bus answers, event outputs and the watchdog error
    property p_rd_quiet; !$past(rd_in) |-> rdata_out == 16'h0000; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
    property p_wsm_wo; rd_in && addr_in == `TWS_OFF_WSM |=> rdata_out == 16'h0000; endproperty
    a_wsm_wo: assert property (p_wsm_wo) else $error("match register readable");
    property p_unmapped; rd_in && addr_in == 24'hFFFF2E |=> rdata_out == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_err_sticky; watchdog_error_out |=> watchdog_error_out; endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("error dropped");
    property p_err_cause; watchdog_error_out |-> started_r; endproperty
    a_err_cause: assert property (p_err_cause) else $error("error while idle");
    property p_uf_width; $rose(timer_underflow_out) |=> timer_underflow_out; endproperty
    a_uf_width: assert property (p_uf_width) else $error("underflow too short");
    property p_uf_gap; $fell(timer_underflow_out) |=> !timer_underflow_out; endproperty
    a_uf_gap: assert property (p_uf_gap) else $error("underflow gap too short");
    property p_irq_rise;
        $rose(timer_irq_out) |-> timer_underflow_out || $past(wr_in) || $past(wr_in, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
    property p_irq_fall; $fell(timer_irq_out) |-> $past(wr_in) || $past(wr_in, 2); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
    c_uf: cover property ($rose(timer_underflow_out));
    c_irq: cover property ($rose(timer_irq_out));
    c_err: cover property ($rose(watchdog_error_out));
endmodule
bind tws_unit tws_unit_properties #(.SLOW_DIV(SLOW_DIV)) i_props (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .freeze_in(freeze_in), .rdata_out(rdata_out),
    .timer_irq_out(timer_irq_out), .timer_underflow_out(timer_underflow_out),
    .watchdog_error_out(watchdog_error_out));

// ===== verilog/tws_map.svh
// register offsets, field positions, reset values and timing counts of the timer/watchdog unit
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH
`define TWS_ADDR_W 24
`define TWS_OFF_CFG 24'hFFFF20
`define TWS_OFF_PRE 24'hFFFF22
`define TWS_OFF_RLD 24'hFFFF24
`define TWS_OFF_CSR 24'hFFFF26
`define TWS_OFF_WDC 24'hFFFF28
`define TWS_OFF_WSM 24'hFFFF2A
`define TWS_OFF_MODE 24'hFFFF2C
`define TWS_CFG_LOCK_CFG 0
`define TWS_CFG_LOCK_PRE 1
`define TWS_CFG_LOCK_TMR 2
`define TWS_CFG_LOCK_WDC 3
`define TWS_CFG_WD_CLKSEL 4
`define TWS_CFG_MATCH_EN 5
`define TWS_CSR_RESTART 0
`define TWS_CSR_TC 1
`define TWS_CSR_IRQ_EN 2
`define TWS_CSR_TOUCHED 3
`define TWS_CSR_FREEZE 4
`define TWS_CFG_RST 6'h00
`define TWS_PRE_RST 3'h0
`define TWS_RLD_RST 16'hFFFF
`define TWS_CSR_RST 5'h00
`define TWS_WDC_RST 8'hFF
`define TWS_SERVICE_KEY 8'h5C
`define TWS_PRE_MAX 3'h5
`define TWS_SLOW_HZ 32768
`define TWS_CLK_HZ 20000000
`define TWS_SLOW_DIV (`TWS_CLK_HZ / (2 * `TWS_SLOW_HZ))
`define TWS_WD_MIN_TICKS 8'h01
`endif

// ===== verilog/tws_pkg.sv
// types shared by the timer/watchdog register set
package tws_pkg;
    typedef enum logic [1:0] {
        TWS_MODE_ACTIVE,
        TWS_MODE_SAVE,
        TWS_MODE_IDLE
    } tws_mode_e;
    typedef logic [23:0] tws_addr_t;
    typedef enum logic [1:0] {
        TWS_WD_IDLE,
        TWS_WD_RUN,
        TWS_WD_FAULT
    } tws_wd_state_e;
endpackage

// ===== verilog/tws_unit.sv
// timer and watchdog unit with lockable register set
//
// Contract
// - seven registers at consecutive even addresses FFFF20h to FFFF2Ch decode.
// - service-match and mode reachable in any mode; others only in active mode.
// - writes to a locked register are ignored; it reads as zero.
// - lock bits are sticky; only reset clears them.
// - configuration is six bits, read/write, zero after reset.
// - config bit 0 locks the configuration register itself.
// - config bit 1 locks the prescaler register.
// - config bit 2 locks reload and control/status registers.
// - config bit 3 locks the watchdog count register.
// - config bit 4 picks watchdog clock: underflow pulse or prescaled tick.
// - config bit 5 picks service: count write, or 5Ch to service-match.
// - prescaler code 0..5 divides slow clock by two to the code.
// - prescaler register is three bits, read/write, zero after reset.
// - reload register is sixteen bits, read/write, all ones after reset.
// - timer reloads from reload value at underflow; period is value plus one.
// - control/status is five bits, read/write, zero after reset.
// - underflow pulses one tick, sets terminal count, irq when enabled.
// - restart reloads timer at next tick, then clears itself.
// - watchdog idle until count or match write; then only reset stops it.
// - late, too-frequent or wrong-key service raises watchdog error.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "tws_map.svh"
module tws_unit #(
    parameter int SLOW_DIV = `TWS_SLOW_DIV
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire tws_pkg::tws_addr_t addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic freeze_in,
    output logic [15:0] rdata_out,
    output logic timer_irq_out,
    output logic timer_underflow_out,
    output logic watchdog_error_out
);
    import tws_pkg::*;

    logic [5:0] cfg_r;
    logic [2:0] pre_r;
    logic [15:0] rld_r;
    logic [4:0] csr_r;
    logic [7:0] wdc_r;
    tws_mode_e mode_r;
    logic [15:0] slow_cnt_r;
    logic slow_tick_r;
    logic [4:0] pre_cnt_r;
    logic tick_r;
    logic [15:0] tmr_r;
    logic uflow_r;
    tws_wd_state_e wd_state_r;
    logic [7:0] wd_cnt_r;
    logic serviced_r;
    logic freeze_meta_r;
    logic freeze_sync_r;

    // address decode shared by read and write paths
    function automatic logic [2:0] tws_decode(input tws_addr_t a);
        case (a)
            `TWS_OFF_CFG: tws_decode = 3'h1;
            `TWS_OFF_PRE: tws_decode = 3'h2;
            `TWS_OFF_RLD: tws_decode = 3'h3;
            `TWS_OFF_CSR: tws_decode = 3'h4;
            `TWS_OFF_WDC: tws_decode = 3'h5;
            `TWS_OFF_WSM: tws_decode = 3'h6;
            `TWS_OFF_MODE: tws_decode = 3'h7;
            default: tws_decode = 3'h0;
        endcase
    endfunction

    logic [2:0] sel;
    logic active;
    logic open_cfg;
    logic open_pre;
    logic open_tmr;
    logic open_wdc;
    logic wr_cfg;
    logic wr_pre;
    logic wr_rld;
    logic wr_csr;
    logic wr_wdc;
    logic wr_wsm;
    logic wd_clk;
    logic wd_service;
    logic wd_bad_key;
    logic frozen;

    assign sel = tws_decode(addr_in);
    assign active = (mode_r == TWS_MODE_ACTIVE);
    // a lock bit closes its register to both reads and writes
    assign open_cfg = active && !cfg_r[`TWS_CFG_LOCK_CFG];
    assign open_pre = active && !cfg_r[`TWS_CFG_LOCK_PRE];
    assign open_tmr = active && !cfg_r[`TWS_CFG_LOCK_TMR];
    assign open_wdc = active && !cfg_r[`TWS_CFG_LOCK_WDC];
    assign wr_cfg = wr_in && (sel == 3'h1) && open_cfg;
    assign wr_pre = wr_in && (sel == 3'h2) && open_pre;
    assign wr_rld = wr_in && (sel == 3'h3) && open_tmr;
    assign wr_csr = wr_in && (sel == 3'h4) && open_tmr;
    assign wr_wdc = wr_in && (sel == 3'h5) && open_wdc;
    assign wr_wsm = wr_in && (sel == 3'h6);
    assign frozen = freeze_sync_r && csr_r[`TWS_CSR_FREEZE];

    // freeze request comes from a debug pin, so synchronise it
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            freeze_meta_r <= 1'b0;
            freeze_sync_r <= 1'b0;
        end
        else
        begin
            freeze_meta_r <= freeze_in;
            freeze_sync_r <= freeze_meta_r;
        end
    end

    // power mode register; software picks the mode the rest of the chip is in
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            mode_r <= TWS_MODE_ACTIVE;
        else if (wr_in && sel == 3'h7)
        begin
            case (wdata_in[1:0])
                2'h0: mode_r <= TWS_MODE_ACTIVE;
                2'h1: mode_r <= TWS_MODE_SAVE;
                default: mode_r <= TWS_MODE_IDLE;
            endcase
        end
    end

    // configuration; ones can only be added to lock bits, never removed
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cfg_r <= `TWS_CFG_RST;
        else if (wr_cfg)
        begin
            cfg_r[3:0] <= cfg_r[3:0] | wdata_in[3:0];
            cfg_r[5:4] <= wdata_in[5:4];
        end
    end

    // prescaler code and reload value
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pre_r <= `TWS_PRE_RST;
            rld_r <= `TWS_RLD_RST;
        end
        else
        begin
            if (wr_pre)
                pre_r <= wdata_in[2:0];
            if (wr_rld)
                rld_r <= wdata_in; // zero is the caller's fault
        end
    end

    // slow tick made from the main clock; at 20 MHz it comes near 65.6 kHz, about twice 32.768 kHz
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            slow_cnt_r <= 16'h0000;
            slow_tick_r <= 1'b0;
        end
        else if (frozen)
            slow_tick_r <= 1'b0;
        else if (slow_cnt_r == 16'(SLOW_DIV - 1))
        begin
            slow_cnt_r <= 16'h0000;
            slow_tick_r <= 1'b1;
        end
        else
        begin
            slow_cnt_r <= slow_cnt_r + 16'h0001;
            slow_tick_r <= 1'b0;
        end
    end

    // prescaled tick; reserved codes fall back to the largest divisor
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pre_cnt_r <= 5'h00;
            tick_r <= 1'b0;
        end
        else if (slow_tick_r)
        begin
            if (pre_cnt_r >= 5'((6'h01 << ((pre_r > `TWS_PRE_MAX) ? `TWS_PRE_MAX : pre_r)) - 6'h01))
            begin
                pre_cnt_r <= 5'h00;
                tick_r <= 1'b1;
            end
            else
            begin
                pre_cnt_r <= pre_cnt_r + 5'h01;
                tick_r <= 1'b0;
            end
        end
        else
            tick_r <= 1'b0;
    end

    // timer down counter; reload at zero gives a period of reload plus one
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            tmr_r <= `TWS_RLD_RST;
            uflow_r <= 1'b0;
        end
        else if (tick_r)
        begin
            if (csr_r[`TWS_CSR_RESTART])
            begin
                tmr_r <= rld_r;
                uflow_r <= 1'b0;
            end
            else if (tmr_r == 16'h0000)
            begin
                tmr_r <= rld_r;
                uflow_r <= 1'b1;
            end
            else
            begin
                tmr_r <= tmr_r - 16'h0001;
                uflow_r <= 1'b0;
            end
        end
        else if (uflow_r && tmr_r != 16'h0000)
        begin
            // pulse stays for one whole tick period
            uflow_r <= uflow_r;
        end
    end

    // control/status; hardware set of flags wins over a software clear
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            csr_r <= `TWS_CSR_RST;
        else
        begin
            if (wr_csr)
            begin
                csr_r[`TWS_CSR_RESTART] <= csr_r[`TWS_CSR_RESTART] | wdata_in[0];
                csr_r[`TWS_CSR_TC] <= wdata_in[1] ? 1'b0 : csr_r[`TWS_CSR_TC];
                csr_r[`TWS_CSR_IRQ_EN] <= wdata_in[2];
                csr_r[`TWS_CSR_TOUCHED] <= wdata_in[3] ? 1'b0 : csr_r[`TWS_CSR_TOUCHED];
                csr_r[`TWS_CSR_FREEZE] <= wdata_in[4];
            end
            if (tick_r && csr_r[`TWS_CSR_RESTART])
                csr_r[`TWS_CSR_RESTART] <= 1'b0;
            if (tick_r && tmr_r == 16'h0000 && !csr_r[`TWS_CSR_RESTART])
                csr_r[`TWS_CSR_TC] <= 1'b1;
            if (wd_service)
                csr_r[`TWS_CSR_TOUCHED] <= 1'b1;
        end
    end

    // watchdog clock and service decode
    assign wd_clk = cfg_r[`TWS_CFG_WD_CLKSEL] ? tick_r :
        (tick_r && tmr_r == 16'h0000 && !csr_r[`TWS_CSR_RESTART]);
    assign wd_service = cfg_r[`TWS_CFG_MATCH_EN] ?
        (wr_wsm && wdata_in[7:0] == `TWS_SERVICE_KEY) : wr_wdc;
    assign wd_bad_key = cfg_r[`TWS_CFG_MATCH_EN] && wr_wsm &&
        wdata_in[7:0] != `TWS_SERVICE_KEY;

    // count register holds the start value
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            wdc_r <= `TWS_WDC_RST;
        else if (wr_wdc)
            wdc_r <= wdata_in[7:0];
    end

    // watchdog: a second service in one watchdog period counts as too often
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wd_state_r <= TWS_WD_IDLE;
            wd_cnt_r <= `TWS_WDC_RST;
            serviced_r <= 1'b0;
        end
        else
        begin
            case (wd_state_r)
                TWS_WD_IDLE:
                    if (wr_wdc || wr_wsm)
                    begin
                        wd_state_r <= TWS_WD_RUN;
                        wd_cnt_r <= wr_wdc ? wdata_in[7:0] : wdc_r;
                        serviced_r <= 1'b0;
                    end
                TWS_WD_RUN:
                    if (wd_bad_key || (wd_service && serviced_r))
                        wd_state_r <= TWS_WD_FAULT;
                    else if (wd_service)
                    begin
                        wd_cnt_r <= wr_wdc ? wdata_in[7:0] : wdc_r;
                        serviced_r <= 1'b1;
                    end
                    else if (wd_clk)
                    begin
                        if (wd_cnt_r < `TWS_WD_MIN_TICKS)
                            wd_state_r <= TWS_WD_FAULT;
                        else
                        begin
                            wd_cnt_r <= wd_cnt_r - 8'h01;
                            serviced_r <= 1'b0;
                        end
                    end
                TWS_WD_FAULT:
                    wd_state_r <= TWS_WD_FAULT;
                default:
                    wd_state_r <= TWS_WD_IDLE;
            endcase
        end
    end

    // outputs straight from flip-flops
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            timer_irq_out <= 1'b0;
            timer_underflow_out <= 1'b0;
            watchdog_error_out <= 1'b0;
        end
        else
        begin
            timer_irq_out <= csr_r[`TWS_CSR_TC] && csr_r[`TWS_CSR_IRQ_EN];
            timer_underflow_out <= uflow_r;
            watchdog_error_out <= (wd_state_r == TWS_WD_FAULT);
        end
    end

    // read data one cycle after the strobe; closed registers read zero
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_out <= 16'h0000;
        else if (rd_in)
        begin
            case (sel)
                3'h1: rdata_out <= open_cfg ? {10'h000, cfg_r} : 16'h0000;
                3'h2: rdata_out <= open_pre ? {13'h0000, pre_r} : 16'h0000;
                3'h3: rdata_out <= open_tmr ? rld_r : 16'h0000;
                3'h4: rdata_out <= open_tmr ? {11'h000, csr_r} : 16'h0000;
                3'h5: rdata_out <= open_wdc ? {8'h00, wd_cnt_r} : 16'h0000;
                3'h7: rdata_out <= {14'h0000, mode_r};
                default: rdata_out <= 16'h0000;
            endcase
        end
        else
            rdata_out <= 16'h0000;
    end
endmodule
